// *** rtl/pha_regs.svh ***
// register select codes, index limits, component codes, mask reset value and extended register count for the palette host port
`ifndef PHA_REGS_SVH
`define PHA_REGS_SVH
`define PHA_SEL_WIDX 2'h0
`define PHA_SEL_DATA 2'h1
`define PHA_SEL_MASK 2'h2
`define PHA_SEL_RIDX 2'h3
`define PHA_IDX_LAST 8'hff
`define PHA_IDX_FIRST 8'h00
`define PHA_COMP_RED 2'h0
`define PHA_COMP_GREEN 2'h1
`define PHA_COMP_BLUE 2'h2
`define PHA_MASK_RESET 8'hff
`define PHA_EXT_COUNT 16
`endif

// *** rtl/pha_pkg.sv ***
// types for the palette host port
package pha_pkg;
  typedef enum logic [1:0] {PHA_IDLE, PHA_LOAD, PHA_STORE} pha_xfer_t;
  typedef logic [23:0] pha_colour_t;
endpackage

// *** rtl/pha_port.sv ***
// palette host access port: host register file, palette ram and pixel look-up
// How it works
// R1 - register_select picks one of four registers
// R2 - palette ram addressed by 8-bit index register
// R3 - indexed mode turns mask location into data
// R4 - host loads index then writes red, green, blue
// R5 - blue write stores joined 24-bit colour word
// R6 - write index advances after each stored triplet
// R7 - read index load fetches entry, then advances
// R8 - host reads red, green, blue in turn
// R9 - after blue read, fetch next and advance
// R10 - index wraps from ff to 00
// R11 - ram transfers run between host strobes
// R12 - host keeps strobes idle several clocks between accesses
// R13 - video keeps previous colour during transfer
// R14 - modulo-3 counter selects red, green, blue
// R15 - index writes clear counter, reads do not
// R16 - index reads change neither index nor state
// R17 - clock must run during palette accesses
// R18 - data reads return component, then advance counter
// R19 - data writes staged; blue triggers ram update
`timescale 1ns/1ps
`include "pha_regs.svh"
module pha_port
  import pha_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [1:0] register_select,
  input wire logic host_wr_n,
  input wire logic host_rd_n,
  input wire logic [7:0] host_wdata,
  output logic [7:0] host_rdata_r,
  input wire logic indexed_access_enable,
  input wire logic [7:0] pixel_index,
  output logic [23:0] pixel_colour_r,
  output logic [3:0] ext_index_r,
  output logic ext_wr_stb,
  output logic [7:0] ext_wdata,
  input wire logic [7:0] ext_rdata
);
  // ------------------------------------------------------------
  // strobe edges
  // ------------------------------------------------------------
  // strobes are taken as synchronous; a falling edge opens an access and a
  // rising edge ends it, so each access acts exactly once
  logic wr_d_r;
  logic rd_d_r;
  logic wr_end;
  logic rd_start;
  logic rd_end;
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      wr_d_r <= 1'b1;
      rd_d_r <= 1'b1;
    end
    else
    begin
      wr_d_r <= host_wr_n;
      rd_d_r <= host_rd_n;
    end
  end
  assign wr_end = host_wr_n && !wr_d_r;
  assign rd_start = !host_rd_n && rd_d_r;
  assign rd_end = host_rd_n && !rd_d_r;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic [7:0] widx_r;
  logic [7:0] ridx_r;
  logic [1:0] comp_r;
  logic [7:0] mask_r;
  logic [7:0] red_r;
  logic [7:0] green_r;
  logic [23:0] hold_r;
  logic [23:0] ram_r [256];
  pha_xfer_t xfer_r;
  logic idx_mode;
  logic wr_data;
  logic rd_data;
  logic blue_now;
  assign idx_mode = indexed_access_enable && (register_select == `PHA_SEL_MASK); // R3
  assign wr_data = wr_end && (register_select == `PHA_SEL_DATA); // R1
  assign rd_data = rd_end && (register_select == `PHA_SEL_DATA); // R1
  assign blue_now = comp_r == `PHA_COMP_BLUE; // R14

  // ------------------------------------------------------------
  // component counter
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      comp_r <= `PHA_COMP_RED;
    else if (wr_end && (register_select == `PHA_SEL_WIDX || register_select == `PHA_SEL_RIDX))
      comp_r <= `PHA_COMP_RED; // R15
    else if (wr_data || rd_data)
      comp_r <= blue_now ? `PHA_COMP_RED : comp_r + 2'h1; // R14 R18
  end

  // ------------------------------------------------------------
  // staging of written components
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      red_r <= 8'h00;
      green_r <= 8'h00;
    end
    else if (wr_data && comp_r == `PHA_COMP_RED)
      red_r <= host_wdata; // R19
    else if (wr_data && comp_r == `PHA_COMP_GREEN)
      green_r <= host_wdata; // R19
  end

  // ------------------------------------------------------------
  // palette ram writes
  // ------------------------------------------------------------
  // ram has no reset: contents are undefined until software loads them
  always_ff @(posedge sys_clk)
  begin
    if (wr_data && blue_now)
      ram_r[widx_r] <= {red_r, green_r, host_wdata}; // R2 R5
  end

  // ------------------------------------------------------------
  // write index
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      widx_r <= `PHA_IDX_FIRST;
    else if (wr_end && register_select == `PHA_SEL_WIDX)
      widx_r <= host_wdata;
    else if (wr_data && blue_now)
      widx_r <= (widx_r == `PHA_IDX_LAST) ? `PHA_IDX_FIRST : widx_r + 8'h01; // R6 R10
  end

  // ------------------------------------------------------------
  // read transfer sequencer
  // ------------------------------------------------------------
  // the fetch waits for both strobes idle so it lands between accesses
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      xfer_r <= PHA_IDLE;
    else
    begin
      case (xfer_r)
        PHA_IDLE:
          if ((wr_end && register_select == `PHA_SEL_RIDX) || (rd_data && blue_now))
            xfer_r <= PHA_LOAD; // R7 R9
        PHA_LOAD:
          if (host_wr_n && host_rd_n)
            xfer_r <= PHA_STORE; // R11 R12
        PHA_STORE:
          xfer_r <= PHA_IDLE;
        default:
          xfer_r <= PHA_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      ridx_r <= `PHA_IDX_FIRST;
    else if (wr_end && register_select == `PHA_SEL_RIDX)
      ridx_r <= host_wdata;
    else if (xfer_r == PHA_STORE)
      ridx_r <= (ridx_r == `PHA_IDX_LAST) ? `PHA_IDX_FIRST : ridx_r + 8'h01; // R7 R9 R10
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      hold_r <= 24'h000000;
    else if (xfer_r == PHA_STORE)
      hold_r <= ram_r[ridx_r]; // R7 R9 R11
  end

  // ------------------------------------------------------------
  // pixel mask and extended registers
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      mask_r <= `PHA_MASK_RESET;
    else if (wr_end && register_select == `PHA_SEL_MASK && !idx_mode)
      mask_r <= host_wdata; // R1
  end

  // in indexed mode the write index low bits name the extended register
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      ext_index_r <= 4'h0;
    else
      ext_index_r <= widx_r[3:0]; // R3
  end
  assign ext_wr_stb = wr_end && idx_mode; // R3
  assign ext_wdata = host_wdata;

  // ------------------------------------------------------------
  // host read data, captured at the strobe's falling edge
  // ------------------------------------------------------------
  // index reads are side effect free: only this capture happens
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      host_rdata_r <= 8'h00;
    else if (rd_start)
    begin
      case (register_select)
        `PHA_SEL_WIDX: host_rdata_r <= widx_r; // R16
        `PHA_SEL_RIDX: host_rdata_r <= ridx_r; // R16
        `PHA_SEL_MASK: host_rdata_r <= idx_mode ? ext_rdata : mask_r; // R3
        `PHA_SEL_DATA:
          case (comp_r)
            `PHA_COMP_RED: host_rdata_r <= hold_r[23:16]; // R18
            `PHA_COMP_GREEN: host_rdata_r <= hold_r[15:8]; // R18
            default: host_rdata_r <= hold_r[7:0]; // R18
          endcase
        default: host_rdata_r <= 8'h00;
      endcase
    end
  end

  // ------------------------------------------------------------
  // video look-up
  // ------------------------------------------------------------
  // the output only refreshes when no host ram transfer is under way,
  // trading two or more frozen pixels per fetch for freedom from sparkle
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      pixel_colour_r <= 24'h000000;
    else if (xfer_r == PHA_IDLE && !(wr_data && blue_now))
      pixel_colour_r <= ram_r[pixel_index & mask_r]; // R13
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  wr_clears_a: assert property (@(posedge sys_clk) disable iff (srst) // R15
    wr_end && register_select == `PHA_SEL_WIDX |=> comp_r == `PHA_COMP_RED)
    else $error("counter not cleared by index write");
  widx_step_a: assert property (@(posedge sys_clk) disable iff (srst) // R6
    wr_data && blue_now && register_select == `PHA_SEL_DATA |=> widx_r == $past(widx_r) + 8'h01)
    else $error("write index did not advance");
  comp_range_a: assert property (@(posedge sys_clk) disable iff (srst) // R14
    comp_r != 2'h3)
    else $error("component counter out of range");
  comp_wrap_a: assert property (@(posedge sys_clk) disable iff (srst) // R18
    rd_data && blue_now |=> comp_r == `PHA_COMP_RED)
    else $error("counter did not wrap after blue");
  idx_read_a: assert property (@(posedge sys_clk) disable iff (srst) // R16
    rd_end && register_select[0] == register_select[1] && xfer_r == PHA_IDLE && host_wr_n
    |=> $stable(widx_r) && $stable(comp_r))
    else $error("index read changed state");
  fetch_done_a: assert property (@(posedge sys_clk) disable iff (srst) // R7
    xfer_r == PHA_LOAD && host_wr_n && host_rd_n |=> ##1 hold_r == ram_r[$past(ridx_r)])
    else $error("holding register not loaded");
  ridx_wrap_a: assert property (@(posedge sys_clk) disable iff (srst) // R10
    xfer_r == PHA_STORE && ridx_r == `PHA_IDX_LAST && !(wr_end && register_select == `PHA_SEL_RIDX)
    |=> ridx_r == `PHA_IDX_FIRST)
    else $error("read index did not wrap");
  video_hold_a: assert property (@(posedge sys_clk) disable iff (srst) // R13
    xfer_r != PHA_IDLE |=> $stable(pixel_colour_r))
    else $error("video changed during transfer");
  ext_strobe_a: assert property (@(posedge sys_clk) disable iff (srst) // R3
    ext_wr_stb |-> indexed_access_enable ##1 $stable(mask_r))
    else $error("indexed write leaked into mask");
  ridx_clears_a: assert property (@(posedge sys_clk) disable iff (srst) // R15
    wr_end && register_select == `PHA_SEL_RIDX |=> comp_r == `PHA_COMP_RED)
    else $error("counter not cleared by read index write");
  widx_wrap_a: assert property (@(posedge sys_clk) disable iff (srst) // R10
    wr_data && blue_now && widx_r == `PHA_IDX_LAST |=> widx_r == `PHA_IDX_FIRST)
    else $error("write index did not wrap");
  stage_red_a: assert property (@(posedge sys_clk) disable iff (srst) // R19
    wr_data && comp_r == `PHA_COMP_RED |=> red_r == $past(host_wdata))
    else $error("red component not staged");
  ram_store_a: assert property (@(posedge sys_clk) disable iff (srst) // R5
    wr_data && blue_now |=> ram_r[$past(widx_r)] == {$past(red_r), $past(green_r), $past(host_wdata)})
    else $error("joined colour word not stored");
  rdata_red_a: assert property (@(posedge sys_clk) disable iff (srst) // R18
    rd_start && register_select == `PHA_SEL_DATA && comp_r == `PHA_COMP_RED |=> host_rdata_r == $past(hold_r[23:16]))
    else $error("red read returned wrong byte");
  ridx_read_a: assert property (@(posedge sys_clk) disable iff (srst) // R16
    rd_end && register_select == `PHA_SEL_RIDX && !wr_end && xfer_r != PHA_STORE |=> $stable(ridx_r))
    else $error("read index changed by index read");
  video_blue_a: assert property (@(posedge sys_clk) disable iff (srst) // R13
    wr_data && blue_now |=> $stable(pixel_colour_r))
    else $error("video changed during ram store");
  blue_write_c: cover property (@(posedge sys_clk) disable iff (srst) wr_data && blue_now);
  blue_read_c: cover property (@(posedge sys_clk) disable iff (srst) rd_data && blue_now);
  wrap_c: cover property (@(posedge sys_clk) disable iff (srst) xfer_r == PHA_STORE && ridx_r == 8'hff);
  ext_c: cover property (@(posedge sys_clk) disable iff (srst) ext_wr_stb);
endmodule

// *** dv/pha_host_model.sv ***
// host bus model that drives the palette port strobes
`timescale 1ns/1ps
module pha_host_model
(
  input wire logic sys_clk,
  output logic [1:0] register_select,
  output logic host_wr_n,
  output logic host_rd_n,
  output logic [7:0] host_wdata,
  input wire logic [7:0] host_rdata_r
);
  // ----------------------------------------
  // strobe cycles
  // ----------------------------------------
  initial
  begin
    register_select = 2'h0;
    host_wr_n = 1'b1;
    host_rd_n = 1'b1;
    host_wdata = 8'h00;
  end
  // idle gap lets the port finish its ram transfer on a running clock
  task automatic gap();
    repeat (3) @(posedge sys_clk);
    #1 host_wdata = ~host_wdata;
  endtask
  task automatic wr(input logic [1:0] sel, input logic [7:0] d);
    @(posedge sys_clk);
    #1 register_select = sel;
    host_wdata = d;
    host_wr_n = 1'b0;
    @(posedge sys_clk);
    #1 host_wr_n = 1'b1;
    gap();
  endtask
  task automatic rd(input logic [1:0] sel, output logic [7:0] d);
    @(posedge sys_clk);
    #1 register_select = sel;
    host_rd_n = 1'b0;
    repeat (2) @(posedge sys_clk);
    #1 d = host_rdata_r;
    host_rd_n = 1'b1;
    gap();
  endtask
endmodule

// *** dv/palette_host_access_port_tb.sv ***
// self-checking bench for the palette host port
`timescale 1ns/1ps
`include "pha_regs.svh"
module palette_host_access_port_tb;
  import pha_pkg::*;
  logic sys_clk;
  logic srst;
  logic [1:0] register_select;
  logic host_wr_n;
  logic host_rd_n;
  logic [7:0] host_wdata;
  logic [7:0] host_rdata_r;
  logic indexed_access_enable;
  logic [7:0] pixel_index;
  logic [23:0] pixel_colour_r;
  logic [3:0] ext_index_r;
  logic ext_wr_stb;
  logic [7:0] ext_wdata;
  logic [7:0] ext_rdata;
  logic [7:0] rv;
  logic [7:0] stb_data;
  int stb_cnt = 0;
  int bad_count = 0;
  int n_checks = 0;
  int cycles = 0;
  pha_port pha_port_i (.sys_clk(sys_clk), .srst(srst), .register_select(register_select),
    .host_wr_n(host_wr_n), .host_rd_n(host_rd_n), .host_wdata(host_wdata), .host_rdata_r(host_rdata_r),
    .indexed_access_enable(indexed_access_enable), .pixel_index(pixel_index),
    .pixel_colour_r(pixel_colour_r), .ext_index_r(ext_index_r), .ext_wr_stb(ext_wr_stb),
    .ext_wdata(ext_wdata), .ext_rdata(ext_rdata));
  pha_host_model pha_host_model_i (.sys_clk(sys_clk), .register_select(register_select), .host_wr_n(host_wr_n),
    .host_rd_n(host_rd_n), .host_wdata(host_wdata), .host_rdata_r(host_rdata_r));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk)
  begin
    cycles++;
    if (ext_wr_stb === 1'b1)
    begin
      stb_cnt++;
      stb_data = ext_wdata;
    end
    // a hung handshake would otherwise stall forever
    if (cycles == 3000)
    begin
      bad_count++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic w(input logic [1:0] s, input logic [7:0] d);
    pha_host_model_i.wr(s, d);
  endtask
  task automatic r(input logic [1:0] s, input logic [23:0] exp);
    pha_host_model_i.rd(s, rv);
    check(rv, exp);
  endtask
  task automatic trip(input pha_colour_t c);
    w(`PHA_SEL_DATA, c[23:16]);
    w(`PHA_SEL_DATA, c[15:8]);
    w(`PHA_SEL_DATA, c[7:0]);
  endtask
  task automatic look(input logic [7:0] idx, input pha_colour_t exp);
    @(posedge sys_clk);
    #1 pixel_index = idx;
    @(posedge sys_clk);
    #1 check(pixel_colour_r, exp);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_wrap();
    w(`PHA_SEL_WIDX, 8'hfe);
    trip(24'h112233);
    trip(24'h445566);
    trip(24'h778899);
    look(8'hfe, 24'h112233);
    look(8'hff, 24'h445566);
    look(8'h00, 24'h778899);
    w(`PHA_SEL_RIDX, 8'hff);
    r(`PHA_SEL_DATA, 24'h44);
    r(`PHA_SEL_DATA, 24'h55);
    r(`PHA_SEL_DATA, 24'h66);
    r(`PHA_SEL_DATA, 24'h77);
    $display("test wrap done");
  endtask
  task automatic t_counter();
    w(`PHA_SEL_WIDX, 8'h10);
    w(`PHA_SEL_DATA, 8'haa);
    w(`PHA_SEL_DATA, 8'hbb);
    w(`PHA_SEL_WIDX, 8'h10);
    w(`PHA_SEL_DATA, 8'hc0);
    r(`PHA_SEL_WIDX, 24'h10);
    w(`PHA_SEL_DATA, 8'hff);
    w(`PHA_SEL_DATA, 8'hee);
    r(`PHA_SEL_WIDX, 24'h11);
    look(8'h10, 24'hc0ffee);
    w(`PHA_SEL_WIDX, 8'h20);
    w(`PHA_SEL_DATA, 8'h01);
    w(`PHA_SEL_RIDX, 8'h10);
    trip(24'h123456);
    look(8'h20, 24'h123456);
    r(`PHA_SEL_RIDX, 24'h11);
    r(`PHA_SEL_DATA, 24'hc0);
    $display("test counter done");
  endtask
  task automatic t_mask();
    w(`PHA_SEL_MASK, 8'h0f);
    r(`PHA_SEL_MASK, 24'h0f);
    look(8'hf0, 24'h778899);
    w(`PHA_SEL_MASK, 8'hff);
    $display("test mask done");
  endtask
  task automatic t_ext();
    int n;
    n = stb_cnt;
    w(`PHA_SEL_MASK, 8'hff);
    check(stb_cnt - n, 0);
    indexed_access_enable = 1'b1;
    w(`PHA_SEL_WIDX, 8'h05);
    w(`PHA_SEL_MASK, 8'ha5);
    check(stb_cnt - n, 1);
    check(stb_data, 24'ha5);
    check(ext_index_r, 24'h5);
    ext_rdata = 8'h3c;
    r(`PHA_SEL_MASK, 24'h3c);
    indexed_access_enable = 1'b0;
    $display("test indexed done");
  endtask
  initial
  begin
    srst = 1'b1;
    indexed_access_enable = 1'b0;
    pixel_index = 8'h00;
    ext_rdata = 8'h00;
    repeat (10) @(posedge sys_clk);
    #1 srst = 1'b0;
    check(host_rdata_r, 24'h0);
    check(pixel_colour_r, 24'h0);
    check(ext_wr_stb, 24'h0);
    $display("test reset done");
    t_wrap();
    t_counter();
    t_mask();
    t_ext();
    tally_and_finish();
  end
endmodule
